/* File: axil_slave_port.sv */
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the owner decodes addresses and supplies read data at once.
`timescale 1ns/1ns
module axil_slave_port
    import monitor_alarm_pkg::*;
#(parameter int ADDR_W = 12) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    output logic                   wr_fire,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_hit,
    output logic                   rd_fire,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_hit
);
    logic aw_full;
    logic w_full;
    logic aw_take;
    logic w_take;
    logic b_done;
    logic r_done;

    assign aw_take = clk_en & s_awvalid & s_awready;
    assign w_take  = clk_en & s_wvalid & s_wready;
    assign b_done  = clk_en & s_bvalid & s_bready;
    assign r_done  = clk_en & s_rvalid & s_rready;
    assign wr_fire = clk_en & aw_full & w_full & ~s_bvalid;
    assign rd_fire = clk_en & s_arvalid & s_arready;
    assign rd_addr = s_araddr;

    // ****************************************************************
    // Write channels
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            wr_addr   <= '0;
            wr_data   <= 32'h0000_0000;
            wr_strb   <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_full   <= 1'b1;
                s_awready <= 1'b0;
                wr_addr   <= s_awaddr;
            end
            if (w_take) begin
                w_full   <= 1'b1;
                s_wready <= 1'b0;
                wr_data  <= s_wdata;
                wr_strb  <= s_wstrb;
            end
            if (wr_fire) begin
                aw_full  <= 1'b0;
                w_full   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end
            if (b_done) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Read channels
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= RESP_OKAY;
        end else if (rd_fire) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_data;
            s_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (r_done) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end
endmodule

/* File: monitor_alarm_pkg.sv */
// Register indices, field layouts and reset values of the alarm bank.
// Assumes a 32-bit AXI4-Lite master with word-aligned accesses.
package monitor_alarm_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_BEEP_ENABLE  = 8'ha3;
    localparam logic [7:0] IDX_SPEECH_TWO   = 8'ha4;
    localparam logic [7:0] IDX_SPEECH_THREE = 8'ha5;
    localparam logic [7:0] IDX_PIN_SELECT   = 8'ha6;
    localparam logic [7:0] IDX_FLASH_PAGES  = 8'ha7;
    localparam logic [7:0] IDX_STATUS_ONE   = 8'ha9;
    localparam logic [7:0] IDX_STATUS_TWO   = 8'haa;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int BIT_USER_BEEP     = 7;
    localparam int BIT_VARIANT_PROBE = 7;
    localparam int BIT_LED_SELECT    = 6;
    localparam int PAGE_BITS         = 5;
    localparam int TRAP_BITS         = 5;
    localparam logic [7:0] PIN_WRITE_MASK = 8'hdf;
    localparam logic [7:0] BEEP_RESET     = 8'h00;
    localparam logic [7:0] PIN_RESET      = 8'h00;
    localparam logic [7:0] SPEECH_RESET   = 8'h00;
    localparam logic [4:0] PAGE_RESET     = 5'h00;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_DECERR    = 2'h3;

    // Alarm sources in the same order as enable bits 6 down to 0.
    typedef struct packed {
        logic fifth_fan;
        logic fourth_fan;
        logic target_temp_three;
        logic target_temp_two;
        logic target_temp_one;
        logic battery_volt;
        logic standby_volt;
    } beep_sources_t;

    typedef struct packed {
        logic second_fan;
        logic first_fan;
        logic temp_two;
        logic temp_one;
        logic plus_five;
        logic plus_three_three;
        logic first_aux_voltage;
        logic core_voltage;
    } status_one_t;

    typedef struct packed {
        logic unused_top;
        logic second_aux_voltage;
        logic temp_three;
        logic case_open;
        logic third_fan;
        logic minus_five;
        logic minus_twelve;
        logic plus_twelve;
    } status_two_t;

    typedef struct packed {
        logic interrupt_or_led_select;
        logic trap_five_pin_select;
        logic trap_four_pin_select;
        logic trap_three_pin_select;
        logic trap_two_pin_select;
        logic trap_one_pin_select;
    } pin_routing_t;

endpackage

/* File: monitor_alarm_status_regs.sv */
// Beep enables, pin routing, flash and speech read-back and live
// limit status of the hardware monitor, behind an AXI4-Lite slave.
// Assumes the comparison engines drive the flag inputs synchronously.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Summary of operation
// - User beep bit forces beep continuously.
// - Bits 6,5 gate fifth, fourth fan alarms.
// - Bits 4..2 gate target temperature alarms.
// - Bit 1 gates battery voltage alarm.
// - Bit 0 gates standby voltage alarm.
// - Beep enable register resets to zero.
// - Speech data bits read at A4h, A5h.
// - Probe bit reads zero on speech variant.
// - Bit 6 picks interrupt or LED output.
// - Bits 4..0 turn trap pins general-purpose.
// - Read-only page count, latched when coding ends.
// - Status one bits 7,6 flag fans.
// - Temperature flags in both status registers.
// - Status one bits 3..0 flag voltages.
// - Status two voltage flags bits 6,2..0.
// - Status two bit 3 flags third fan.
// - Status two bit 4 mirrors case-open.
// - Status registers live, read-only, reset zero.
module monitor_alarm_status_regs
    import monitor_alarm_pkg::*;
#(parameter int ADDR_W = 12) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    input  wire beep_sources_t     beep_sources,
    input  wire status_one_t       status_one_in,
    input  wire status_two_t       status_two_in,
    input  wire logic [31:0]       speech_read_data,
    input  wire logic [4:0]        flash_page_count,
    input  wire logic              page_coding_done,
    input  wire logic              gpio_variant_strap,
    input  wire logic              system_mgmt_interrupt_out,
    input  wire logic              led_drive_out,
    output logic                   beep_request,
    output logic                   shared_pin_out,
    output pin_routing_t           pin_routing
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic [7:0] index_of(
        input logic [ADDR_W-1:0] addr
    );
        index_of = addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        is_mapped = (addr[1:0] == 2'h0)
                  && (addr[ADDR_W-1:10] == '0)
                  && ((idx == IDX_BEEP_ENABLE)
                   || (idx == IDX_SPEECH_TWO)
                   || (idx == IDX_SPEECH_THREE)
                   || (idx == IDX_PIN_SELECT)
                   || (idx == IDX_FLASH_PAGES)
                   || (idx == IDX_STATUS_ONE)
                   || (idx == IDX_STATUS_TWO));
    endfunction

    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_hit;
    logic              rd_fire;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_hit;
    logic [7:0]        wr_index;
    logic [7:0]        rd_index;
    logic              wr_byte;
    logic              wr_beep;
    logic              wr_pins;
    logic [7:0]        rd_byte;
    logic [7:0]        pin_readback;

    logic [7:0]        beep_enable;
    logic [7:0]        pin_select;
    logic [7:0]        speech_two;
    logic [7:0]        speech_three;
    logic [4:0]        page_count;
    status_one_t       status_one;
    status_two_t       status_two;
    logic              gpio_variant;
    logic              strap_taken;
    logic              next_beep_request;
    logic              next_shared_pin;

    axil_slave_port #(.ADDR_W(ADDR_W)) bus_port (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_en    (clk_en),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_fire   (wr_fire),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_hit    (wr_hit),
        .rd_fire   (rd_fire),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_hit    (rd_hit)
    );

    assign wr_index = index_of(wr_addr);
    assign rd_index = index_of(rd_addr);
    assign wr_hit   = is_mapped(wr_addr);
    assign rd_hit   = is_mapped(rd_addr);
    assign wr_byte  = wr_fire & wr_hit & wr_strb[0];
    assign wr_beep  = wr_byte & (wr_index == IDX_BEEP_ENABLE);
    assign wr_pins  = wr_byte & (wr_index == IDX_PIN_SELECT);

    assign pin_readback = {pin_select[BIT_VARIANT_PROBE] & gpio_variant,
                           pin_select[BIT_LED_SELECT], 1'b0,
                           pin_select[TRAP_BITS-1:0]};

    assign rd_byte =
        (rd_index == IDX_BEEP_ENABLE)  ? beep_enable  :
        (rd_index == IDX_SPEECH_TWO)   ? speech_two   :
        (rd_index == IDX_SPEECH_THREE) ? speech_three :
        (rd_index == IDX_PIN_SELECT)   ? pin_readback :
        (rd_index == IDX_FLASH_PAGES)  ? {3'h0, page_count} :
        (rd_index == IDX_STATUS_ONE)   ? status_one   :
        (rd_index == IDX_STATUS_TWO)   ? status_two   : 8'h00;
    assign rd_data = rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    // ****************************************************************
    // Software registers
    // ****************************************************************
    // beep enable reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            beep_enable <= BEEP_RESET;
        end else if (clk_en && wr_beep) begin
            beep_enable <= wr_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_select <= PIN_RESET;
        end else if (clk_en && wr_pins) begin
            pin_select <= wr_data[7:0] & PIN_WRITE_MASK;
        end
    end

    // The variant strap is caught once, on the first enabled cycle
    // after reset is released.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken  <= 1'b0;
            gpio_variant <= 1'b0;
        end else if (clk_en && !strap_taken) begin
            strap_taken  <= 1'b1;
            gpio_variant <= gpio_variant_strap;
        end
    end

    // ****************************************************************
    // Read-only mirrors
    // ****************************************************************
    // speech data bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speech_two   <= SPEECH_RESET;
            speech_three <= SPEECH_RESET;
        end else if (clk_en) begin
            speech_two   <= speech_read_data[23:16];
            speech_three <= speech_read_data[31:24];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_count <= PAGE_RESET;
        end else if (clk_en && page_coding_done) begin
            page_count <= flash_page_count[PAGE_BITS-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_one <= STATUS_RESET;
            status_two <= STATUS_RESET;
        end else if (clk_en) begin
            status_one <= status_one_in;
            status_two <= {1'b0, status_two_in[6:0]};
        end
    end

    // ****************************************************************
    // Beep and pin outputs
    // ****************************************************************
    // gated sources
    assign next_beep_request = beep_enable[BIT_USER_BEEP]
                             | (|(beep_enable[6:0] & beep_sources));
    assign next_shared_pin = pin_select[BIT_LED_SELECT] ? led_drive_out
                           : system_mgmt_interrupt_out;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            beep_request   <= 1'b0;
            shared_pin_out <= 1'b0;
            pin_routing    <= '0;
        end else if (clk_en) begin
            beep_request   <= next_beep_request;
            shared_pin_out <= next_shared_pin;
            pin_routing    <= {pin_select[BIT_LED_SELECT],
                               pin_select[TRAP_BITS-1:0]};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Checks start one edge after the release of reset has been seen.
    logic reset_done;
    always_ff @(posedge aclk) begin
        reset_done <= aresetn;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !reset_done);

    a_user_beep_on: assert property (
        clk_en && beep_enable[7] |=> beep_request)
        else $error("user beep override did not hold beep");

    a_fan_beep_gate: assert property (
        clk_en && beep_enable[6] && beep_sources.fifth_fan
        |=> beep_request)
        else $error("enabled fifth fan alarm did not beep");

    a_fan_four_gate: assert property (
        clk_en && beep_enable[5] && beep_sources.fourth_fan
        |=> beep_request)
        else $error("enabled fourth fan alarm did not beep");

    a_target_beep_gate: assert property (
        clk_en && beep_enable[4] && beep_sources.target_temp_three
        |=> beep_request)
        else $error("enabled target temperature alarm did not beep");

    a_battery_beep_gate: assert property (
        clk_en && beep_enable[1] && beep_sources.battery_volt
        |=> beep_request)
        else $error("enabled battery alarm did not beep");

    a_standby_beep_gate: assert property (
        clk_en && beep_enable[0] && beep_sources.standby_volt
        |=> beep_request)
        else $error("enabled standby alarm did not beep");

    a_beep_quiet: assert property (
        clk_en && !beep_enable[7]
        && ((beep_enable[6:0] & beep_sources) == 7'h00)
        |=> !beep_request)
        else $error("beep raised with no enabled alarm");

    a_reset_clears: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> (beep_enable == BEEP_RESET)
        && (status_one == STATUS_RESET) && (status_two == STATUS_RESET)
        && (page_count == PAGE_RESET) && !beep_request)
        else $error("registers not cleared by reset");

    a_speech_bytes: assert property (
        rd_fire && (rd_index == IDX_SPEECH_THREE) && rd_hit
        |=> s_rvalid && (s_rdata[7:0] == $past(speech_three)))
        else $error("speech byte read returned wrong data");

    a_probe_variant: assert property (
        rd_fire && rd_hit && (rd_index == IDX_PIN_SELECT)
        && !gpio_variant |=> !s_rdata[7])
        else $error("probe bit read nonzero on speech variant");

    a_shared_pin: assert property (
        clk_en |=> shared_pin_out == ($past(pin_select[6])
        ? $past(led_drive_out) : $past(system_mgmt_interrupt_out)))
        else $error("shared pin shows wrong function");

    a_trap_routing: assert property (
        clk_en && wr_pins ##1 clk_en
        |=> pin_routing[4:0] == $past(wr_data[4:0], 2))
        else $error("trap pin selection did not follow write");

    a_page_count: assert property (
        clk_en && page_coding_done
        |=> page_count == $past(flash_page_count))
        else $error("page count not captured");

    a_status_one: assert property (
        clk_en |=> status_one == $past(status_one_in))
        else $error("status one does not follow comparisons");

    a_status_two: assert property (
        clk_en |=> status_two[6:0] == $past(status_two_in[6:0])
        && !status_two[7])
        else $error("status two does not follow comparisons");

    a_case_open: assert property (
        clk_en && status_two_in.case_open ##1 clk_en
        && status_two_in.case_open |-> status_two.case_open)
        else $error("case open level not mirrored");

    a_status_frozen: assert property (
        !clk_en |=> $stable(status_one) && $stable(status_two))
        else $error("status register changed while frozen");

    c_write_beep: cover property (
        wr_beep ##[1:20] rd_fire && (rd_index == IDX_BEEP_ENABLE));
    c_user_beep: cover property (clk_en && beep_enable[7] ##1 beep_request);
    c_probe_read: cover property (
        wr_pins ##[1:20] rd_fire && (rd_index == IDX_PIN_SELECT));
    c_unmapped_read: cover property (rd_fire && !rd_hit);
endmodule

/* File: testbench.sv */
// Self-checking bench for the alarm and status register bank.
// Assumes the design package and the bank module are compiled first.
`timescale 1ns/1ns
module testbench;
    import monitor_alarm_pkg::*;
    logic          aclk = 1'b0;
    logic          aresetn;
    logic [11:0]   awaddr, araddr;
    logic          awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid;
    logic [31:0]   wdata, rdata, sp, rv;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, rr;
    beep_sources_t src;
    status_one_t   s1;
    status_two_t   s2;
    pin_routing_t  route;
    logic [4:0]    pages;
    logic          done, smi, led, beep, shp;
    logic          ce = 1'b1, strap = 1'b1;
    logic [7:0]    en, pd;
    int            errors = 0;
    int            check_count = 0;
    int            seed = 41741;
    int            i;
    logic [7:0]    idx [7] = '{8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9,
                               8'haa};
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

    always #20 aclk = ~aclk;

    monitor_alarm_status_regs #(.ADDR_W(12)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(ce),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rvalid), .s_rready(rready), .beep_sources(src),
        .status_one_in(s1), .status_two_in(s2),
        .speech_read_data(sp), .flash_page_count(pages),
        .page_coding_done(done), .gpio_variant_strap(strap),
        .system_mgmt_interrupt_out(smi), .led_drive_out(led),
        .beep_request(beep), .shared_pin_out(shp), .pin_routing(route)
    );

    // ****************************************************************
    // Bus tasks and expectations
    // ****************************************************************
    function automatic logic exp_beep(logic [7:0] e, logic [6:0] s);
        return e[7] | (|(e[6:0] & s));
    endfunction

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        awaddr <= {2'h0, a, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !(bvalid && bready); n++) begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end
        rr = bresp;
        bready <= 1'b0;
        if (n == 40) begin
            errors++;
            give_verdict();
        end
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= {2'h0, a, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && !(rvalid && rready); n++) begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
        end
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        if (n == 40) begin
            errors++;
            give_verdict();
        end
        @(posedge aclk);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {aresetn, awaddr, araddr, awvalid, wvalid, bready} = '0;
        {arvalid, rready, wdata, sp, src, s1, s2, pages} = '0;
        {done, smi, led} = '0;
        wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 7; i++) begin
            rd(idx[i]);
            `CHK(rv, 32'h0)
        end
        $display("test reset_values done");
        for (i = 0; i < 10; i++) begin
            en = i == 0 ? 8'h80 : i == 1 ? 8'h00 : 8'($random(seed));
            pd = i == 0 ? 8'hff : 8'($random(seed));
            wr(IDX_BEEP_ENABLE, en);
            wr(IDX_PIN_SELECT, pd);
            src <= i < 2 ? {7{i[0]}} : 7'($random(seed));
            s1 <= 8'($random(seed));
            s2 <= 8'($random(seed));
            sp <= $random(seed);
            smi <= 1'($random(seed));
            led <= 1'($random(seed));
            repeat (2) @(posedge aclk);
            `CHK(beep, exp_beep(en, src))
            `CHK(route, {pd[6], pd[4:0]})
            `CHK(shp, pd[6] ? led : smi)
            rd(IDX_BEEP_ENABLE);
            `CHK(rv, {24'h0, en})
            rd(IDX_PIN_SELECT);
            `CHK(rv, {24'h0, pd & 8'hdf})
            wr(IDX_STATUS_TWO, 8'hff);
            `CHK(rr, RESP_OKAY)
            rd(IDX_STATUS_ONE);
            `CHK(rv, {24'h0, s1})
            rd(IDX_STATUS_TWO);
            `CHK(rv, {25'h0, s2[6:0]})
            rd(IDX_SPEECH_TWO);
            `CHK(rv, {24'h0, sp[23:16]})
            rd(IDX_SPEECH_THREE);
            `CHK(rv, {24'h0, sp[31:24]})
            pd = i == 0 ? 8'h1f : 8'($random(seed));
            pages <= pd[4:0];
            done <= 1'b1;
            @(posedge aclk);
            done <= 1'b0;
            pages <= ~pd[4:0];
            @(posedge aclk);
            rd(IDX_FLASH_PAGES);
            `CHK(rv, {27'h0, pd[4:0]})
        end
        $display("test random_traffic done");
        // Clock enable low must hold the beep against new sources.
        pd = {1'b0, src};
        ce <= 1'b0;
        src <= ~src;
        s1 <= ~s1;
        repeat (3) @(posedge aclk);
        `CHK(beep, exp_beep(en, pd[6:0]))
        ce <= 1'b1;
        $display("test clock_freeze done");
        rd(8'ha8);
        `CHK({rr, rv}, {RESP_DECERR, 32'h0})
        wr(8'ha8, 8'hff);
        `CHK(rr, RESP_DECERR)
        aresetn <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(IDX_BEEP_ENABLE);
        `CHK(rv, 32'h0)
        rd(IDX_PIN_SELECT);
        `CHK(rv, 32'h0)
        wr(IDX_PIN_SELECT, 8'h80);
        rd(IDX_PIN_SELECT);
        `CHK(rv, 32'h0)
        $display("test second_reset done");
        give_verdict();
    end
endmodule
